/* core/ppfm_pkg.sv */
// Package of constants for the port pin function mux
// Function
// - Low reset pin holds start-up state
// - Internal reset pulls reset pin low
// - Interrupt pin senses edge or edge-and-level
// - Sensitivity bit set by reset, write once
// - Capture triggers on programmed pin edge
// - Four eight-bit ports, per-pin direction, data
// - All port pins inputs after reset, except fourth port bit six (compare)
// - Serial enable makes bit zero receive input
// - Serial enable makes bit one transmit output
// - PWM enables route channels to port pins
package ppfm_pkg;
  localparam int PORT_W = 8;                      // Width of each port
  localparam int PWM_N  = 5;                      // Number of PWM channels
  localparam logic [7:0] DIR_RST  = 8'h00;        // All inputs after reset
  localparam logic [7:0] DATA_RST = 8'h00;        // Output latches cleared
  localparam logic       SENS_RST = 1'b1;         // Edge-and-level after reset
  localparam int BIT_RX  = 0;                     // Receive pin position
  localparam int BIT_TX  = 1;                     // Transmit pin position
  localparam int BIT_CMP = 6;                     // Compare pin position
  localparam int PORT_N  = 4;                     // Number of ports
  localparam logic [2:0] PWM_POS0 = 3'd2;         // Position of PWM channel 0
  localparam logic [2:0] PWM_POS4 = 3'd7;         // Position of PWM channel 4
endpackage

/* core/ppfm_edge.sv */
// Edge detector for one synchronous input pin: rising, falling and selected edge
`timescale 1ns/1ps
module ppfm_edge (
  // Clock and control
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Pin and selection
  input  wire logic pin,
  input  wire logic rise_sel,
  // Results
  output logic      rise_p,
  output logic      fall_p,
  output logic      sel_p
);
  logic prev_r;   // Pin level one cycle ago
  logic armed_r;  // Low until one level has been seen after reset

  // Remember previous level; edges are masked until prev_r holds a real
  // sample, so a pin that rests low shows no false edge after reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_r  <= 1'b1;
      armed_r <= 1'b0;
      rise_p  <= 1'b0;
      fall_p  <= 1'b0;
      sel_p   <= 1'b0;
    end else if (clk_en) begin
      prev_r  <= pin;
      armed_r <= 1'b1;
      rise_p  <= armed_r & pin & ~prev_r;
      fall_p  <= armed_r & ~pin & prev_r;
      sel_p   <= armed_r & (rise_sel ? (pin & ~prev_r) : (~pin & prev_r));
    end
  end
endmodule

/* core/ppfm_top.sv */
// Pin function mux: reset pin, interrupt sense, capture edge and four ports
`timescale 1ns/1ps
module ppfm_top (
  // Clock, reset and enable
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  // Reset pin, open drain
  input  wire logic       reset_pin_n_i,
  output logic            reset_pin_o,
  output logic            reset_pin_oe,
  input  wire logic       internal_reset,
  output logic            core_reset,
  // Interrupt pin and sensitivity option
  input  wire logic       irq_pin_n,
  input  wire logic       sens_wr,
  input  wire logic       sens_wdata,
  output logic            irq_req,
  // Capture pin
  input  wire logic       capture_input_pin,
  input  wire logic       capture_rise_sel,
  output logic            capture_event,
  // First three ports: pins; programming for all four ports
  input  wire logic [7:0] first_port_pins_i,
  output logic [7:0]      first_port_pins_o,
  output logic [7:0]      first_port_pins_oe,
  input  wire logic [7:0] second_port_pins_i,
  output logic [7:0]      second_port_pins_o,
  output logic [7:0]      second_port_pins_oe,
  input  wire logic [7:0] third_port_pins_i,
  output logic [7:0]      third_port_pins_o,
  output logic [7:0]      third_port_pins_oe,
  input  wire logic [1:0] port_sel,
  input  wire logic       dir_wr,
  input  wire logic       data_wr,
  input  wire logic [7:0] port_wdata,
  output logic [7:0]      port_rdata,
  // Fourth port pins and alternate functions
  input  wire logic [7:0] fourth_port_pins_i,
  output logic [7:0]      fourth_port_pins_o,
  output logic [7:0]      fourth_port_pins_oe,
  input  wire logic       serial_enable,
  input  wire logic       serial_tx_data,
  output logic            serial_receive_pin,
  input  wire logic       compare_level,
  input  wire logic [4:0] pwm_enable,
  input  wire logic [4:0] pwm_channel_outputs
);
  logic [7:0] dir_r  [ppfm_pkg::PORT_N];  // Direction per port, 1 drives
  logic [7:0] data_r [ppfm_pkg::PORT_N];  // Output latch per port
  logic       sens_r;                     // 1 edge-and-level, 0 edge only
  logic       sens_done_r;                // Write-once lock
  logic       rst_any;                    // System reset or low reset pin
  logic       irq_fall;                   // Falling edge of interrupt pin
  logic [7:0] d_oe_nxt, d_o_nxt;          // Fourth port drive
  logic [7:0] pins_i [ppfm_pkg::PORT_N];  // Pin inputs by port

  // Reset pin low, or the system reset, holds all port, sensitivity and interrupt state at start-up
  assign rst_any = sys_rst | ~reset_pin_n_i;

  assign pins_i[0] = first_port_pins_i;
  assign pins_i[1] = second_port_pins_i;
  assign pins_i[2] = third_port_pins_i;
  assign pins_i[3] = fourth_port_pins_i;

  // Open-drain drive of the reset pin on internal resets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reset_pin_o  <= 1'b0;
      reset_pin_oe <= 1'b0;
      core_reset   <= 1'b1;
    end else if (clk_en) begin
      reset_pin_o  <= 1'b0;                 // Only ever drives low
      reset_pin_oe <= internal_reset;
      core_reset   <= ~reset_pin_n_i | internal_reset;
    end
  end

  // Sensitivity option: set by reset, one write allowed afterwards
  always_ff @(posedge clk) begin
    if (rst_any) begin
      sens_r      <= ppfm_pkg::SENS_RST;
      sens_done_r <= 1'b0;
    end else if (clk_en && sens_wr && !sens_done_r) begin
      sens_r      <= sens_wdata;
      sens_done_r <= 1'b1;
    end
  end

  // Interrupt edge detector, falling edge on the active-low pin
  ppfm_edge u_irq_edge (
    .clk      (clk),
    .sys_rst  (rst_any),
    .clk_en   (clk_en),
    .pin      (irq_pin_n),
    .rise_sel (1'b0),
    .rise_p   (),
    .fall_p   (irq_fall),
    .sel_p    ()
  );

  // Capture edge detector with programmed polarity
  ppfm_edge u_cap_edge (
    .clk      (clk),
    .sys_rst  (rst_any),
    .clk_en   (clk_en),
    .pin      (capture_input_pin),
    .rise_sel (capture_rise_sel),
    .rise_p   (),
    .fall_p   (),
    .sel_p    (capture_event)
  );

  // Request: edge always, low level too when level sensing is chosen
  always_ff @(posedge clk) begin
    if (rst_any) begin
      irq_req <= 1'b0;
    end else if (clk_en) begin
      irq_req <= irq_fall | (sens_r & ~irq_pin_n);
    end
  end

  // Direction and data latches; direction reset clears every direction bit, fourth port bit six included
  always_ff @(posedge clk) begin
    if (rst_any) begin
      for (int p = 0; p < ppfm_pkg::PORT_N; p++) begin
        dir_r[p]  <= ppfm_pkg::DIR_RST;
        data_r[p] <= ppfm_pkg::DATA_RST;
      end
    end else if (clk_en) begin
      if (dir_wr) begin
        dir_r[port_sel] <= port_wdata;
      end
      if (data_wr) begin
        data_r[port_sel] <= port_wdata;
      end
    end
  end

  // Fourth port drive; alternate functions take priority over the latch
  always_comb begin
    d_oe_nxt = dir_r[3];
    d_o_nxt  = data_r[3];
    if (serial_enable) begin
      d_oe_nxt[ppfm_pkg::BIT_RX] = 1'b0;
      d_oe_nxt[ppfm_pkg::BIT_TX] = 1'b1;
      d_o_nxt[ppfm_pkg::BIT_TX]  = serial_tx_data;
    end
    for (int c = 0; c < ppfm_pkg::PWM_N - 1; c++) begin
      if (pwm_enable[c]) begin
        d_oe_nxt[int'(ppfm_pkg::PWM_POS0) + c] = 1'b1;
        d_o_nxt[int'(ppfm_pkg::PWM_POS0) + c]  = pwm_channel_outputs[c];
      end
    end
    if (pwm_enable[4]) begin
      d_oe_nxt[ppfm_pkg::PWM_POS4] = 1'b1;
      d_o_nxt[ppfm_pkg::PWM_POS4]  = pwm_channel_outputs[4];
    end
    // Compare position ignores the direction latch entirely
    d_oe_nxt[ppfm_pkg::BIT_CMP] = 1'b1;
    d_o_nxt[ppfm_pkg::BIT_CMP]  = compare_level;
  end

  // Registered pin drives for all four ports
  always_ff @(posedge clk) begin
    if (rst_any) begin
      first_port_pins_oe  <= ppfm_pkg::DIR_RST;
      second_port_pins_oe <= ppfm_pkg::DIR_RST;
      third_port_pins_oe  <= ppfm_pkg::DIR_RST;
      fourth_port_pins_oe <= ppfm_pkg::DIR_RST;
      first_port_pins_o   <= ppfm_pkg::DATA_RST;
      second_port_pins_o  <= ppfm_pkg::DATA_RST;
      third_port_pins_o   <= ppfm_pkg::DATA_RST;
      fourth_port_pins_o  <= ppfm_pkg::DATA_RST;
      serial_receive_pin  <= 1'b1;
    end else if (clk_en) begin
      first_port_pins_oe  <= dir_r[0];
      second_port_pins_oe <= dir_r[1];
      third_port_pins_oe  <= dir_r[2];
      fourth_port_pins_oe <= d_oe_nxt;
      first_port_pins_o   <= data_r[0];
      second_port_pins_o  <= data_r[1];
      third_port_pins_o   <= data_r[2];
      fourth_port_pins_o  <= d_o_nxt;
      serial_receive_pin  <= serial_enable ? fourth_port_pins_i[ppfm_pkg::BIT_RX] : 1'b1;
    end
  end

  // Read back: output bits show the latch, input bits the pin; fourth port bit six the pin
  always_ff @(posedge clk) begin
    if (rst_any) begin
      port_rdata <= 8'h00;
    end else if (clk_en) begin
      port_rdata <= (data_r[port_sel] & dir_r[port_sel]) |
                    (pins_i[port_sel] & ~dir_r[port_sel]);
      if (port_sel == 2'd3) begin
        port_rdata[ppfm_pkg::BIT_CMP] <= fourth_port_pins_i[ppfm_pkg::BIT_CMP];
      end
    end
  end

  // Checks
  reset_oe_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_en |=> (reset_pin_oe == $past(internal_reset)))
    else $error("reset pin drive not following internal reset");
  cmp_oe_a: assert property (@(posedge clk) disable iff (rst_any)
    clk_en |=> fourth_port_pins_oe[6])
    else $error("compare pin not driven");
  ports_in_a: assert property (@(posedge clk)
    rst_any |=> (first_port_pins_oe == 8'h00 && fourth_port_pins_oe == 8'h00))
    else $error("port not input after reset");
  sens_once_a: assert property (@(posedge clk) disable iff (rst_any)
    sens_done_r && !$past(rst_any) |=> $stable(sens_r))
    else $error("sensitivity changed after first write");
  rx_hiz_a: assert property (@(posedge clk) disable iff (rst_any)
    clk_en && serial_enable |=> !fourth_port_pins_oe[0])
    else $error("receive pin driven while serial on");
  tx_drv_a: assert property (@(posedge clk) disable iff (rst_any)
    clk_en && serial_enable |=> fourth_port_pins_oe[1])
    else $error("transmit pin not driven");
  pwm_drv_a: assert property (@(posedge clk) disable iff (rst_any)
    clk_en && pwm_enable[4] |=> fourth_port_pins_o[7] == $past(pwm_channel_outputs[4]))
    else $error("pwm channel four not routed");
  level_irq_a: assert property (@(posedge clk) disable iff (rst_any)
    clk_en && sens_r && !irq_pin_n |=> irq_req)
    else $error("level interrupt missed");

  // Pin high, then low, then one more enabled cycle: detector plus request stage
  sequence irq_drop_s;
    clk_en && irq_pin_n ##1 clk_en && !irq_pin_n ##1 clk_en;
  endsequence
  edge_irq_a: assert property (@(posedge clk) disable iff (rst_any)
    irq_drop_s |=> irq_req)
    else $error("edge interrupt missed");
endmodule

/* verification/ppfm_board.sv */
// Board model: resolves each port pin from the device, board drivers and pull-ups
`timescale 1ns/1ps
module ppfm_board (
  // Device side
  input  wire logic [7:0] dev_o,
  input  wire logic [7:0] dev_oe,
  // Board drivers, stronger than the device
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // Resolved pin levels
  output logic      [7:0] pin
);
  // Released pins fall to the pull-up level, never keep a stale value
  assign pin = (ext_en & ext_val) | (~ext_en & dev_oe & dev_o) | (~ext_en & ~dev_oe);
endmodule

/* verification/ppfm_top_tb_top.sv */
// Self-checking bench for the port pin function mux
`timescale 1ns/1ps
module ppfm_top_tb_top;
  // Device control and status
  logic clk, sys_rst, clk_en, reset_pin_n_i, reset_pin_o, reset_pin_oe, rst_drv_n;
  logic internal_reset, core_reset, irq_pin_n, sens_wr, sens_wdata, irq_req;
  logic capture_input_pin, capture_rise_sel, capture_event, dir_wr, data_wr;
  logic serial_enable, serial_tx_data, serial_receive_pin, compare_level;
  logic [1:0] port_sel;
  logic [4:0] pwm_enable, pwm_channel_outputs;
  logic [7:0] port_wdata, port_rdata, ext_en, ext_val;
  // Port pins
  logic [7:0] first_port_pins_i, first_port_pins_o, first_port_pins_oe;
  logic [7:0] second_port_pins_i, second_port_pins_o, second_port_pins_oe;
  logic [7:0] third_port_pins_i, third_port_pins_o, third_port_pins_oe;
  logic [7:0] fourth_port_pins_i, fourth_port_pins_o, fourth_port_pins_oe;
  logic [7:0] oe_a [4];
  logic [7:0] o_a [4];
  int err_total, n_tests;

  assign oe_a = '{first_port_pins_oe, second_port_pins_oe, third_port_pins_oe,
                  fourth_port_pins_oe};
  assign o_a = '{first_port_pins_o, second_port_pins_o, third_port_pins_o, fourth_port_pins_o};
  // Open-drain reset line with a board pull-up
  assign reset_pin_n_i = rst_drv_n & ~(reset_pin_oe & ~reset_pin_o);

  ppfm_top u_dut (.*);
  ppfm_board u_b0 (.dev_o(first_port_pins_o), .dev_oe(first_port_pins_oe), .ext_en,
                   .ext_val, .pin(first_port_pins_i));
  ppfm_board u_b1 (.dev_o(second_port_pins_o), .dev_oe(second_port_pins_oe), .ext_en,
                   .ext_val, .pin(second_port_pins_i));
  ppfm_board u_b2 (.dev_o(third_port_pins_o), .dev_oe(third_port_pins_oe), .ext_en,
                   .ext_val, .pin(third_port_pins_i));
  ppfm_board u_b3 (.dev_o(fourth_port_pins_o), .dev_oe(fourth_port_pins_oe), .ext_en,
                   .ext_val, .pin(fourth_port_pins_i));

  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Direction then data write; pins settle two cycles later
  task automatic wr(input logic [1:0] p, input logic [7:0] d, input logic [7:0] v);
    port_sel = p;
    port_wdata = d;
    dir_wr = 1'h1;
    cyc(1);
    dir_wr = 1'h0;
    data_wr = 1'h1;
    port_wdata = v;
    cyc(1);
    data_wr = 1'h0;
    cyc(3);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Mixed directions; input half is read back from the board
  task automatic t_ports();
    ext_en = 8'h0f;
    ext_val = 8'h03;
    for (int p = 0; p < 3; p++) begin
      wr(2'(p), 8'hf0, 8'ha5);
      chk(oe_a[p], 8'hf0);
      chk(o_a[p] & 8'hf0, 8'ha0);
      chk(port_rdata, 8'ha3);
    end
    ext_en = 8'h00;
  endtask
  // Clock enable low: write pulses are lost and the port keeps its state
  task automatic t_freeze();
    clk_en = 1'h0;
    wr(2'd1, 8'h0f, 8'h0f);
    chk(oe_a[1], 8'hf0);
    clk_en = 1'h1;
    cyc(3);
    chk(oe_a[1], 8'hf0);
    chk(o_a[1], 8'ha5);
  endtask
  // Bit six stays an output and reads the live pin
  task automatic t_portd();
    compare_level = 1'h1;
    wr(2'd3, 8'hff, 8'h8d);
    chk(fourth_port_pins_oe, 8'hff);
    chk(fourth_port_pins_o, 8'hcd);
    wr(2'd3, 8'h00, 8'h00);
    chk(fourth_port_pins_oe, 8'h40);
    ext_en = 8'h40;
    cyc(3);
    chk(port_rdata, 8'hbf);
    ext_en = 8'h00;
    cyc(3);
    chk(port_rdata, 8'hff);
  endtask
  task automatic t_serial();
    wr(2'd3, 8'h03, 8'h01);
    serial_enable = 1'h1;
    serial_tx_data = 1'h1;
    ext_en = 8'h01;
    cyc(3);
    chk(fourth_port_pins_oe & 8'h03, 8'h02);
    chk(fourth_port_pins_o & 8'h02, 8'h02);
    chk({7'h0, serial_receive_pin}, 8'h01);
    ext_val = 8'h00;
    serial_tx_data = 1'h0;
    cyc(3);
    chk(fourth_port_pins_o & 8'h02, 8'h00);
    chk({7'h0, serial_receive_pin}, 8'h00);
    serial_enable = 1'h0;
    ext_en = 8'h00;
    cyc(3);
    chk(fourth_port_pins_oe & 8'h03, 8'h03);
    chk(fourth_port_pins_o & 8'h03, 8'h01);
  endtask
  // Latch holds ones so a channel at zero proves the override
  task automatic t_pwm();
    logic [7:0] m;
    wr(2'd3, 8'h00, 8'hff);
    for (int c = 0; c < 5; c++) begin
      m = (c < 4) ? 8'h04 << c : 8'h80;
      pwm_enable = 5'h01 << c;
      pwm_channel_outputs = 5'h00;
      cyc(3);
      chk(fourth_port_pins_oe & m, m);
      chk(fourth_port_pins_o & m, 8'h00);
      pwm_channel_outputs = 5'h1f;
      cyc(3);
      chk(fourth_port_pins_o & m, m);
    end
    pwm_enable = 5'h00;
    cyc(3);
    chk(fourth_port_pins_oe & 8'hbf, 8'h00);
  endtask
  // Level mode from reset, then edge only; the second write must not undo it
  task automatic t_irq();
    int cnt;
    irq_pin_n = 1'h0;
    cyc(6);
    chk({7'h0, irq_req}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      irq_pin_n = 1'h1;
      sens_wdata = 1'(k);
      sens_wr = 1'h1;
      cyc(1);
      sens_wr = 1'h0;
      cyc(3);
      irq_pin_n = 1'h0;
      cnt = 0;
      // Sampled at each falling edge, so every one-cycle pulse is seen once
      repeat (6) begin
        cyc(1);
        if (irq_req === 1'h1) begin
          cnt++;
        end
      end
      chk({7'h0, irq_req}, 8'h00);
      chk(8'(cnt), 8'h01);
    end
    irq_pin_n = 1'h1;
  endtask
  task automatic cap(input logic r, input logic v, input int n);
    int cnt;
    capture_rise_sel = r;
    cyc(1);
    capture_input_pin = v;
    cnt = 0;
    repeat (6) begin
      cyc(1);
      if (capture_event === 1'h1) begin
        cnt++;
      end
    end
    chk(8'(cnt), 8'(n));
  endtask
  task automatic t_resets();
    wr(2'd0, 8'hff, 8'hff);
    rst_drv_n = 1'h0;
    cyc(2);
    chk({7'h0, core_reset}, 8'h01);
    rst_drv_n = 1'h1;
    cyc(3);
    chk(first_port_pins_oe, 8'h00);
    internal_reset = 1'h1;
    cyc(3);
    chk({6'h0, reset_pin_oe, reset_pin_o}, 8'h02);
    chk({7'h0, core_reset}, 8'h01);
    internal_reset = 1'h0;
    cyc(4);
    chk({7'h0, reset_pin_oe}, 8'h00);
  endtask

  // Main sequence
  initial begin
    sys_rst = 1'h1;
    {rst_drv_n, clk_en, irq_pin_n} = 3'h7;
    {internal_reset, sens_wr, sens_wdata, capture_input_pin, capture_rise_sel} = 5'h00;
    {dir_wr, data_wr, serial_enable, serial_tx_data, compare_level, port_sel} = 7'h00;
    {pwm_enable, pwm_channel_outputs, port_wdata, ext_en, ext_val} = 34'h0_0000_0000;
    {err_total, n_tests} = 64'h0;
    cyc(8);
    chk({7'h0, core_reset}, 8'h01);
    sys_rst = 1'h0;
    cyc(3);
    for (int p = 0; p < 4; p++) chk(oe_a[p] & 8'hbf, 8'h00);
    t_ports();
    t_freeze();
    t_portd();
    t_serial();
    t_pwm();
    t_irq();
    cap(1'h1, 1'h1, 1);
    cap(1'h1, 1'h0, 0);
    cap(1'h0, 1'h1, 0);
    cap(1'h0, 1'h0, 1);
    t_resets();
    results();
  end
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    #15000;
    err_total++;
    results();
  end
endmodule
